// file: rtl/tmc_pkg.sv
// Shared constants and carriers for the tape maintenance command mux
package tmc_pkg;

  localparam int unsigned CHAR_W       = 8;
  localparam int unsigned ATE_W        = 9;
  localparam int unsigned STAT_W       = 8;
  localparam int unsigned PAT_LEN      = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_PATTERN   = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_INT_STAT  = 8'h0c;
  localparam logic [7:0] OFF_INT_MASK  = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_DIR     = 0;
  localparam int unsigned CTRL_RW      = 1;
  localparam int unsigned CTRL_DENS    = 2;
  localparam int unsigned CTRL_MANUAL  = 3;
  localparam int unsigned CTRL_GO      = 4;
  localparam int unsigned CTRL_LCLR    = 5;
  localparam int unsigned CTRL_W       = 4;

  // Interrupt status fields
  localparam int unsigned INT_PARITY   = 0;
  localparam int unsigned INT_MANCMD   = 1;
  localparam int unsigned INT_W        = 2;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST    = 4'h0;
  localparam logic [7:0]        PATTERN_RST = 8'h00;
  localparam logic [INT_W-1:0]  MASK_RST    = 2'h0;

  // Manual command byte: base code with switch fields in low bits
  localparam logic [CHAR_W-1:0] MAN_CMD_BASE = 8'h80;

  // Odd parity expected on formatter command bytes
  localparam logic CMD_PAR_ODD = 1'b1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic              cmd_valid;
    logic [CHAR_W-1:0] cmd;
    logic              cmd_par;
    logic              wdata_valid;
    logic [CHAR_W-1:0] wdata;
  } tmc_fmt_in_t;

  typedef struct packed {
    logic              rdata_valid;
    logic [CHAR_W-1:0] rdata;
    logic [ATE_W-1:0]  ate;
    logic [STAT_W-1:0] status;
  } tmc_fmt_out_t;

  typedef struct packed {
    logic              rdata_valid;
    logic [CHAR_W-1:0] rdata;
    logic [ATE_W-1:0]  ate;
    logic [STAT_W-1:0] status;
    logic              online;
    logic              wr_ring;
    logic              wchar_req;
    logic              panel_mode_sel;
  } tmc_tu_in_t;

  typedef struct packed {
    logic              cmd_valid;
    logic [CHAR_W-1:0] cmd;
    logic              wdata_valid;
    logic [CHAR_W-1:0] wdata;
    logic              dir_fwd;
    logic              write_sel;
    logic              dens_high;
    logic              head_en;
    logic              mode_sel;
  } tmc_tu_out_t;

endpackage

// file: rtl/tmc_adapter.sv
// Maintenance adapter between formatter and transport bus, with AHB-Lite registers
//
// Notes on behaviour
// - Manual setting blocks data, command, amplitude error and status both ways.
// - In manual mode switches source commands and data, looking like formatter traffic.
// - Manual commands reach the transport only while it is on-line.
// - In manual mode the panel mode select switch is ignored.
// - Write data repeats eight characters; switch n sets character n all ones or zeros.
// - Manual-mode lamp lit whenever selector is in manual.
// - Formatter command bytes are parity checked; errors light the parity lamp.
// - All switch settings take effect at once, tape moving or not.
// - Write and erase heads stay disabled without a write-enable ring.
// - Read/write selector low means read; leaving write on overwrites on rewind.
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps

module tmc_adapter (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // AHB-Lite slave
  input  wire logic                  i_hsel,
  input  wire logic [7:0]            i_haddr,
  input  wire logic [1:0]            i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic [2:0]            i_hsize,
  input  wire logic [31:0]           i_hwdata,
  input  wire logic                  i_hready,
  output logic      [31:0]           o_hrdata,
  output logic                       o_hreadyout,
  output logic                       o_hresp,
  // Formatter side
  input  wire tmc_pkg::tmc_fmt_in_t  i_fmt,
  output tmc_pkg::tmc_fmt_out_t      o_fmt,
  // Transport bus side
  input  wire tmc_pkg::tmc_tu_in_t   i_tu,
  output tmc_pkg::tmc_tu_out_t       o_tu,
  // Lamps and interrupt
  output logic                       o_manual_mode_lamp,
  output logic                       o_parity_error_lamp,
  output logic                       o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [tmc_pkg::CTRL_W-1:0]  ctrl_reg;
  logic [tmc_pkg::CTRL_W-1:0]  ctrl_next;
  logic [7:0]                  pattern_reg;
  logic [7:0]                  pattern_next;
  logic [tmc_pkg::INT_W-1:0]   int_stat_reg;
  logic [tmc_pkg::INT_W-1:0]   int_stat_next;
  logic [tmc_pkg::INT_W-1:0]   int_mask_reg;
  logic [tmc_pkg::INT_W-1:0]   int_mask_next;
  logic                        par_lamp_reg;
  logic                        par_lamp_next;
  logic                        go_reg;
  logic                        go_next;
  logic [2:0]                  char_idx_reg;
  logic [2:0]                  char_idx_next;
  logic [31:0]                 hrdata_reg;
  logic [31:0]                 hrdata_next;
  logic                        wr_pend_reg;
  logic [7:0]                  wr_addr_reg;
  tmc_pkg::tmc_fmt_out_t       fmt_out_reg;
  tmc_pkg::tmc_fmt_out_t       fmt_out_next;
  tmc_pkg::tmc_tu_out_t        tu_out_reg;
  tmc_pkg::tmc_tu_out_t        tu_out_next;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire        addr_phase   = i_hsel & i_hready & (i_htrans == tmc_pkg::HTRANS_NONSEQ);
  wire        rd_take      = addr_phase & ~i_hwrite;
  wire        wr_take      = addr_phase & i_hwrite;
  wire        sel_ctrl     = (i_haddr == tmc_pkg::OFF_CTRL);
  wire        sel_pattern  = (i_haddr == tmc_pkg::OFF_PATTERN);
  wire        sel_status   = (i_haddr == tmc_pkg::OFF_STATUS);
  wire        sel_int_stat = (i_haddr == tmc_pkg::OFF_INT_STAT);
  wire        sel_int_mask = (i_haddr == tmc_pkg::OFF_INT_MASK);
  wire        wr_ctrl      = wr_pend_reg & (wr_addr_reg == tmc_pkg::OFF_CTRL);
  wire        wr_pattern   = wr_pend_reg & (wr_addr_reg == tmc_pkg::OFF_PATTERN);
  wire        wr_mask      = wr_pend_reg & (wr_addr_reg == tmc_pkg::OFF_INT_MASK);
  wire        rd_int_stat  = rd_take & sel_int_stat;

  wire        manual       = ctrl_reg[tmc_pkg::CTRL_MANUAL];
  wire        sw_dir       = ctrl_reg[tmc_pkg::CTRL_DIR];
  wire        sw_rw        = ctrl_reg[tmc_pkg::CTRL_RW];
  wire        sw_dens      = ctrl_reg[tmc_pkg::CTRL_DENS];

  ////////////////////////////////////////////////////////////////////////////
  // Event and datapath decode

  wire        par_calc     = ^{i_fmt.cmd, i_fmt.cmd_par};
  wire        par_err      = i_fmt.cmd_valid & (par_calc != tmc_pkg::CMD_PAR_ODD);
  wire        man_cmd_fire = manual & go_reg & i_tu.online;
  wire        man_wchar    = manual & i_tu.wchar_req;
  wire [tmc_pkg::CHAR_W-1:0] pat_char =
                             {tmc_pkg::CHAR_W{pattern_reg[char_idx_reg]}};
  wire [tmc_pkg::CHAR_W-1:0] man_cmd =
                             tmc_pkg::MAN_CMD_BASE | {5'h00, sw_dens, sw_rw, sw_dir};
  wire [tmc_pkg::INT_W-1:0]  int_events = {man_cmd_fire, par_err};

  wire [31:0] status_word  = {24'h000000, i_tu.panel_mode_sel, char_idx_reg, i_tu.wr_ring,
                              i_tu.online, par_lamp_reg, manual};
  wire [31:0] rd_mux       = sel_ctrl     ? {28'h0000000, ctrl_reg} :
                             sel_pattern  ? {24'h000000, pattern_reg} :
                             sel_status   ? status_word :
                             sel_int_stat ? {30'h0, int_stat_reg} :
                             sel_int_mask ? {30'h0, int_mask_reg} :
                                            32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  assign ctrl_next     = wr_ctrl ? i_hwdata[tmc_pkg::CTRL_W-1:0] : ctrl_reg;
  assign pattern_next  = wr_pattern ? i_hwdata[7:0] : pattern_reg;
  assign int_mask_next = wr_mask ? i_hwdata[tmc_pkg::INT_W-1:0] : int_mask_reg;
  // Event set wins over read clear
  assign int_stat_next = (rd_int_stat ? '0 : int_stat_reg) | int_events;
  assign go_next       = wr_ctrl ? i_hwdata[tmc_pkg::CTRL_GO] : (go_reg & ~man_cmd_fire);
  assign par_lamp_next = par_err | (par_lamp_reg & ~(wr_ctrl & i_hwdata[tmc_pkg::CTRL_LCLR]));
  assign char_idx_next = ~manual ? 3'h0 : (man_wchar ? char_idx_reg + 3'h1 : char_idx_reg);
  assign hrdata_next   = rd_take ? rd_mux : hrdata_reg;

  // Formatter-bound traffic dropped in manual mode
  assign fmt_out_next.rdata_valid = ~manual & i_tu.rdata_valid;
  assign fmt_out_next.rdata       = manual ? '0 : i_tu.rdata;
  assign fmt_out_next.ate         = manual ? '0 : i_tu.ate;
  assign fmt_out_next.status      = manual ? '0 : i_tu.status;

  // Transport-bound traffic from formatter or from switches
  assign tu_out_next.cmd_valid   = manual ? man_cmd_fire : i_fmt.cmd_valid;
  assign tu_out_next.cmd         = manual ? man_cmd : i_fmt.cmd;
  assign tu_out_next.wdata_valid = manual ? (man_wchar & sw_rw) : i_fmt.wdata_valid;
  assign tu_out_next.wdata       = manual ? pat_char : i_fmt.wdata;
  assign tu_out_next.dir_fwd     = manual & sw_dir;
  assign tu_out_next.write_sel   = manual & sw_rw;
  assign tu_out_next.dens_high   = manual & sw_dens;
  // Heads enabled only on a ringed reel; write stays on through rewind if left set
  assign tu_out_next.head_en     = i_tu.wr_ring & (manual ? sw_rw : 1'b1);
  assign tu_out_next.mode_sel    = manual ? 1'b0 : i_tu.panel_mode_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg     <= tmc_pkg::CTRL_RST;
      pattern_reg  <= tmc_pkg::PATTERN_RST;
      int_mask_reg <= tmc_pkg::MASK_RST;
      int_stat_reg <= '0;
      go_reg       <= 1'b0;
      par_lamp_reg <= 1'b0;
      char_idx_reg <= 3'h0;
    end else begin
      ctrl_reg     <= ctrl_next;
      pattern_reg  <= pattern_next;
      int_mask_reg <= int_mask_next;
      int_stat_reg <= int_stat_next;
      go_reg       <= go_next;
      par_lamp_reg <= par_lamp_next;
      char_idx_reg <= char_idx_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hrdata_reg  <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      hrdata_reg  <= hrdata_next;
      wr_pend_reg <= wr_take;
      wr_addr_reg <= wr_take ? i_haddr : wr_addr_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fmt_out_reg <= '0;
      tu_out_reg  <= '0;
    end else begin
      fmt_out_reg <= fmt_out_next;
      tu_out_reg  <= tu_out_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_hrdata            = hrdata_reg;
  assign o_hreadyout         = 1'b1;
  assign o_hresp             = 1'b0;
  assign o_fmt               = fmt_out_reg;
  assign o_tu                = tu_out_reg;
  assign o_manual_mode_lamp  = manual;
  assign o_parity_error_lamp = par_lamp_reg;
  assign o_irq               = |(int_stat_reg & int_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Traffic blocked in manual, passed in auto

  block_fmt_out_a: assert property (manual |=>
    (!o_fmt.rdata_valid && o_fmt.rdata == '0 && o_fmt.status == '0 && o_fmt.ate == '0))
    else $error("formatter traffic leaked");

  block_cmd_a: assert property ((manual && !go_reg) |=>
    !o_tu.cmd_valid)
    else $error("formatter command leaked");

  block_wdata_a: assert property ((manual && !i_tu.wchar_req) |=>
    !o_tu.wdata_valid)
    else $error("formatter write data leaked");

  auto_cmd_pass_a: assert property (!manual |=>
    (o_tu.cmd_valid == $past(i_fmt.cmd_valid) && o_tu.cmd == $past(i_fmt.cmd)))
    else $error("command not passed in auto");

  auto_data_pass_a: assert property (!manual |=>
    (o_tu.wdata_valid == $past(i_fmt.wdata_valid) && o_tu.wdata == $past(i_fmt.wdata)))
    else $error("write data not passed in auto");

  auto_fmt_pass_a: assert property (!manual |=>
    (o_fmt.rdata_valid == $past(i_tu.rdata_valid) && o_fmt.rdata == $past(i_tu.rdata)
     && o_fmt.ate == $past(i_tu.ate) && o_fmt.status == $past(i_tu.status)))
    else $error("transport traffic not passed in auto");

  // Manual command source

  man_cmd_src_a: assert property ((manual && go_reg && i_tu.online && !wr_ctrl) |=>
    (o_tu.cmd_valid && o_tu.cmd == (tmc_pkg::MAN_CMD_BASE | {5'h00, $past(ctrl_reg[2:0])})))
    else $error("manual command not issued");

  cmd_int_a: assert property (man_cmd_fire |=> int_stat_reg[tmc_pkg::INT_MANCMD])
    else $error("manual command event not recorded");

  cmd_clear_a: assert property ((rd_int_stat && !man_cmd_fire) |=>
    !int_stat_reg[tmc_pkg::INT_MANCMD])
    else $error("command event not cleared by read");

  online_gate_a: assert property ((manual && !i_tu.online) |=> !o_tu.cmd_valid)
    else $error("command sent while off-line");

  online_wait_a: assert property ((manual && go_reg && !i_tu.online && !wr_ctrl) |=> go_reg)
    else $error("pending command lost while off-line");

  go_clear_a: assert property ((man_cmd_fire && !wr_ctrl) |=> !go_reg)
    else $error("manual command issued twice");

  // Panel mode select

  panel_ignore_a: assert property (manual |=> !o_tu.mode_sel)
    else $error("panel mode select not ignored");

  panel_pass_a: assert property (!manual |=> o_tu.mode_sel == $past(i_tu.panel_mode_sel))
    else $error("panel mode select not passed in auto");

  // Test pattern

  pattern_char_a: assert property ((manual && i_tu.wchar_req && sw_rw && !wr_ctrl && !wr_pattern) |=>
    (o_tu.wdata_valid && o_tu.wdata == {tmc_pkg::CHAR_W{pattern_reg[$past(char_idx_reg)]}}))
    else $error("wrong test pattern character");

  pattern_wrap_a: assert property ((manual && char_idx_reg == 3'h7 && i_tu.wchar_req && !wr_ctrl) |=>
    char_idx_reg == 3'h0)
    else $error("pattern index did not wrap");

  idx_step_a: assert property ((manual && i_tu.wchar_req) |=>
    char_idx_reg == $past(char_idx_reg) + 3'h1)
    else $error("pattern index did not advance");

  idx_hold_a: assert property (!manual |=> char_idx_reg == 3'h0)
    else $error("pattern index not parked in auto");

  // Lamps and events

  manual_lamp_a: assert property (wr_ctrl |=>
    o_manual_mode_lamp == $past(i_hwdata[tmc_pkg::CTRL_MANUAL]))
    else $error("manual lamp mismatch");

  parity_lamp_a: assert property (par_err |=>
    (o_parity_error_lamp && int_stat_reg[tmc_pkg::INT_PARITY]))
    else $error("parity error not flagged");

  lamp_sticky_a: assert property ((o_parity_error_lamp && !(wr_ctrl && i_hwdata[tmc_pkg::CTRL_LCLR])) |=>
    o_parity_error_lamp)
    else $error("parity lamp dropped");

  lamp_clear_a: assert property ((wr_ctrl && i_hwdata[tmc_pkg::CTRL_LCLR] && !par_err) |=>
    !o_parity_error_lamp)
    else $error("parity lamp not cleared");

  no_false_err_a: assert property ((!o_parity_error_lamp && !i_fmt.cmd_valid) |=>
    !o_parity_error_lamp)
    else $error("parity lamp lit without a command byte");

  stat_clear_a: assert property ((rd_int_stat && !par_err) |=>
    !int_stat_reg[tmc_pkg::INT_PARITY])
    else $error("parity event not cleared by read");

  // Switch levels and heads

  ctrl_write_a: assert property (wr_ctrl |=>
    ctrl_reg == $past(i_hwdata[tmc_pkg::CTRL_W-1:0]))
    else $error("switch setting not taken");

  pattern_write_a: assert property (wr_pattern |=>
    pattern_reg == $past(i_hwdata[7:0]))
    else $error("pattern setting not taken");

  switch_now_a: assert property ((wr_ctrl && i_hwdata[tmc_pkg::CTRL_MANUAL]) |=> ##1
    (o_tu.dir_fwd == $past(i_hwdata[tmc_pkg::CTRL_DIR], 2)))
    else $error("switch change delayed");

  ring_gate_a: assert property (!i_tu.wr_ring |=> !o_tu.head_en)
    else $error("heads enabled without ring");

  head_auto_a: assert property (!manual |=> o_tu.head_en == $past(i_tu.wr_ring))
    else $error("heads not following ring in auto");

  read_sel_a: assert property ((manual && !sw_rw) |=> (!o_tu.write_sel && !o_tu.wdata_valid))
    else $error("write active with read selected");

  write_sel_a: assert property ((manual && sw_rw) |=>
    (o_tu.write_sel && o_tu.head_en == $past(i_tu.wr_ring)))
    else $error("write path not enabled");

  dens_dir_a: assert property (manual |=>
    (o_tu.dens_high == $past(sw_dens) && o_tu.dir_fwd == $past(sw_dir)))
    else $error("direction or density wrong");

  auto_levels_a: assert property (!manual |=> (!o_tu.dir_fwd && !o_tu.dens_high && !o_tu.write_sel))
    else $error("switch levels driven in auto");

endmodule // tmc_adapter

// file: bench/tmc_fmt_model.sv
// Formatter model sending command bytes toward the adapter
`timescale 1ns/100ps

module tmc_fmt_model (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_send,
  input  wire logic [7:0]      i_cmd,
  input  wire logic            i_bad_par,
  output tmc_pkg::tmc_fmt_in_t o_fmt
);
  // Idle fields keep changing so stale bytes never look valid
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fmt <= '0;
    end else begin
      o_fmt.cmd_valid   <= i_send;
      o_fmt.cmd         <= i_send ? i_cmd : ~o_fmt.cmd;
      o_fmt.cmd_par     <= i_send ? (~^i_cmd) ^ i_bad_par : ~o_fmt.cmd_par;
      o_fmt.wdata_valid <= 1'b0;
      o_fmt.wdata       <= o_fmt.wdata + 8'h01;
    end
  end
endmodule // tmc_fmt_model

// file: bench/tb_tape_maintenance_command_mux.sv
// Self-checking bench for the tape maintenance command mux
`timescale 1ns/100ps

module tb_tape_maintenance_command_mux;
  logic                  i_clk   = 1'b0;
  logic                  i_rst_n = 1'b0;
  logic                  hsel    = 1'b0;
  logic                  hwrite  = 1'b0;
  logic [7:0]            haddr   = 8'h00;
  logic [1:0]            htrans  = 2'h0;
  logic [31:0]           hwdata  = 32'h0;
  logic                  send    = 1'b0;
  logic                  bad     = 1'b0;
  logic [7:0]            fcmd    = 8'h00;
  logic [31:0]           hrdata;
  logic                  hready;
  logic                  hresp;
  logic                  man_lamp;
  logic                  par_lamp;
  logic                  irq;
  logic [7:0]            last_cmd;
  logic [7:0]            wd_q[$];
  tmc_pkg::tmc_fmt_in_t  fmt;
  tmc_pkg::tmc_fmt_out_t fmt_o;
  tmc_pkg::tmc_tu_in_t   tu      = '0;
  tmc_pkg::tmc_tu_out_t  tu_o;
  int                    num_errors = 0;
  int                    compares   = 0;
  int                    cmd_cnt    = 0;

  always #2.5 i_clk = ~i_clk;

  tmc_fmt_model i_fmt_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_send(send), .i_cmd(fcmd), .i_bad_par(bad),
                             .o_fmt(fmt));
  tmc_adapter i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_fmt(fmt), .o_fmt(fmt_o), .i_tu(tu), .o_tu(tu_o),
    .o_manual_mode_lamp(man_lamp), .o_parity_error_lamp(par_lamp), .o_irq(irq));

  // Pulses seen on the transport side, sampled before the edge updates
  always @(posedge i_clk) begin
    if (tu_o.cmd_valid === 1'b1) begin
      cmd_cnt++;
      last_cmd = tu_o.cmd;
    end
    if (tu_o.wdata_valid === 1'b1) wd_q.push_back(tu_o.wdata);
  end

  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge i_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        chk("hready timeout", 32'h1, 32'h0);
        wrap_up();
      end
      @(posedge i_clk);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= tmc_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
    repeat (2) @(posedge i_clk);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(nm, e, r);
    repeat (2) @(posedge i_clk);
  endtask

  task automatic fsend(input logic [7:0] c, input logic b);
    @(posedge i_clk);
    send <= 1'b1;
    fcmd <= c;
    bad  <= b;
    @(posedge i_clk);
    send <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_auto();
    int c0;
    rd_chk("ctrl reset", tmc_pkg::OFF_CTRL, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    @(posedge i_clk);
    tu.status         <= 8'h3c;
    tu.ate            <= 9'h155;
    tu.panel_mode_sel <= 1'b1;
    tu.rdata_valid    <= 1'b1;
    tu.rdata          <= 8'h6b;
    c0 = cmd_cnt;
    fsend(8'h17, 1'b0);
    chk("auto cmd", c0 + 1, cmd_cnt);
    chk("auto cmd byte", 32'h17, {24'h0, last_cmd});
    chk("auto fmt out", {6'h0, 1'b1, 8'h6b, 9'h155, 8'h3c}, {6'h0, fmt_o});
    chk("panel passed", 32'h1, {31'h0, tu_o.mode_sel});
    chk("good parity", 32'h0, {30'h0, par_lamp, man_lamp});
    $display("test auto done");
  endtask

  task automatic t_manual();
    int c0;
    wr(tmc_pkg::OFF_INT_MASK, 32'h2);
    wr(tmc_pkg::OFF_CTRL, 32'h8);
    chk("manual lamp", 32'h1, {31'h0, man_lamp});
    chk("blocked fmt out", 32'h0, {6'h0, fmt_o});
    chk("panel ignored", 32'h0, {31'h0, tu_o.mode_sel});
    c0 = cmd_cnt;
    fsend(8'h17, 1'b0);
    chk("blocked cmd", c0, cmd_cnt);
    wr(tmc_pkg::OFF_CTRL, 32'h1d);
    chk("offline cmd", c0, cmd_cnt);
    @(posedge i_clk);
    tu.online <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk("online cmd", c0 + 1, cmd_cnt);
    chk("manual cmd byte", 32'h85, {24'h0, last_cmd});
    chk("fwd high dens", 32'h3, {30'h0, tu_o.dir_fwd, tu_o.dens_high});
    chk("cmd irq", 32'h1, {31'h0, irq});
    rd_chk("status", tmc_pkg::OFF_STATUS, 32'h85);
    rd_chk("cmd int stat", tmc_pkg::OFF_INT_STAT, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(tmc_pkg::OFF_CTRL, 32'h8);
    chk("rev low dens", 32'h0, {30'h0, tu_o.dir_fwd, tu_o.dens_high});
    $display("test manual done");
  endtask

  task automatic t_pattern();
    logic [7:0] pat;
    pat = 8'h5a;
    wr(tmc_pkg::OFF_CTRL, 32'h0);
    wr(tmc_pkg::OFF_PATTERN, {24'h0, pat});
    tu.wr_ring <= 1'b1;
    wr(tmc_pkg::OFF_CTRL, 32'ha);
    chk("heads write", 32'h3, {30'h0, tu_o.head_en, tu_o.write_sel});
    wd_q.delete();
    repeat (9) @(posedge i_clk) tu.wchar_req <= 1'b1;
    @(posedge i_clk) tu.wchar_req <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("char count", 32'h9, wd_q.size());
    for (int i = 0; i < 9; i++) chk("pattern char", {24'h0, {8{pat[i % 8]}}}, {24'h0, wd_q[i]});
    @(posedge i_clk) tu.wr_ring <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("no ring heads", 32'h0, {31'h0, tu_o.head_en});
    tu.wr_ring <= 1'b1;
    wr(tmc_pkg::OFF_CTRL, 32'h8);
    chk("read heads", 32'h0, {30'h0, tu_o.head_en, tu_o.write_sel});
    wd_q.delete();
    @(posedge i_clk) tu.wchar_req <= 1'b1;
    @(posedge i_clk) tu.wchar_req <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("read no data", 32'h0, wd_q.size());
    $display("test pattern done");
  endtask

  task automatic t_parity();
    wr(tmc_pkg::OFF_INT_MASK, 32'h0);
    fsend(8'h17, 1'b1);
    chk("parity lamp", 32'h1, {31'h0, par_lamp});
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(tmc_pkg::OFF_INT_MASK, 32'h1);
    chk("parity irq", 32'h1, {31'h0, irq});
    rd_chk("parity int stat", tmc_pkg::OFF_INT_STAT, 32'h1);
    chk("irq after read", 32'h0, {31'h0, irq});
    wr(tmc_pkg::OFF_CTRL, 32'h20);
    chk("lamp cleared", 32'h0, {31'h0, par_lamp});
    $display("test parity done");
  endtask

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_auto();
    t_manual();
    t_pattern();
    t_parity();
    wrap_up();
  end
endmodule // tb_tape_maintenance_command_mux
